// *** bench/dmad_chk_sva.sv ***
`timescale 1ns/10ps
module dmad_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire dmad_pkg::dmad_dreq_t dreq,
  input wire dmad_pkg::dmad_dans_t dans,
  input wire dmad_pkg::dmad_sfr_t sfr,
  input wire logic [7:0] sfr_rdata,
  input wire dmad_pkg::dmad_creq_t creq,
  input wire logic cready,
  input wire dmad_pkg::dmad_cans_t cans
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic dt, up, dir, bm, er, any;
  assign dt = ce && dreq.valid;
  assign up = dreq.addr[7];
  assign dir = dreq.mode == dmad_pkg::DMAD_DIRECT;
  assign bm = dreq.mode == dmad_pkg::DMAD_BIT;
  assign any = sfr.rd || sfr.wr;
  assign er = ce && creq.valid && cready && creq.op == dmad_pkg::DMAD_FERASE;
  ack_next_a:
    assert property (dt |=> dans.ack) else $error("ack late");
  sfr_route_a:
    assert property (dt && dir && up |-> any && sfr.addr == dreq.addr[6:0])
    else $error("direct upper not routed");
  sfr_data_a:
    assert property (dt && dir && up && !dreq.we |=>
      dans.rdata == $past(sfr_rdata)) else $error("register data lost");
  ind_ram_a:
    assert property (dt && dreq.mode == dmad_pkg::DMAD_INDIRECT |-> !any)
    else $error("indirect hit register space");
  low_ram_a:
    assert property (dt && dir && !up |-> !any) else $error("low hit regs");
  bit_sfr_a:
    assert property (dt && bm && up |->
      sfr.rd && sfr.addr == {dreq.addr[6:3], 3'h0}) else $error("bit byte");
  erase_busy_a:
    assert property (er |=> !cready [*8]) else $error("erase not busy");
  erase_len_a:
    assert property (er |-> ##[513:513] cans.ack) else $error("erase length");
  cover property (er);
  cover property (dt && dir && up);
  cover property (dt && bm && !up);
  cover property (dt && dreq.mode == dmad_pkg::DMAD_REG);
endmodule

// *** bench/dmad_decode_tb.sv ***
`timescale 1ns/10ps
module dmad_decode_tb;
  logic clk = 0, rstn = 0, ce = 1, cready, rb;
  logic [1:0] psw_bank = 2'h0;
  logic [7:0] sfr_rdata, rd;
  dmad_pkg::dmad_dreq_t dreq = '0;
  dmad_pkg::dmad_dans_t dans;
  dmad_pkg::dmad_sfr_t sfr;
  dmad_pkg::dmad_xreq_t xreq = '0;
  dmad_pkg::dmad_xans_t xans;
  dmad_pkg::dmad_creq_t creq = '0;
  dmad_pkg::dmad_cans_t cans;
  int bad_count = 0, num_checks = 0, n;
  always #5 clk = ~clk;
  dmad_decode dut_u (.clk(clk), .rstn(rstn), .ce(ce), .psw_bank(psw_bank),
    .dreq(dreq), .dans(dans), .sfr(sfr), .sfr_rdata(sfr_rdata), .xreq(xreq),
    .xans(xans), .creq(creq), .cready(cready), .cans(cans));
  dmad_sfr_model sfr_u (.clk(clk), .sfr(sfr), .sfr_rdata(sfr_rdata));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] a, e);
    num_checks++;
    if (a !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, a, e);
    end
  endtask
  // mode codes: 0 direct, 1 indirect, 2 bank register, 3 bit
  task automatic da(input logic w, input logic [1:0] m,
                    input logic [7:0] a, d, input logic b = 1'b0);
    @(posedge clk);
    dreq <= {1'b1, w, m, a, d, b};
    @(posedge clk);
    dreq.valid <= 1'b0;
    #1 rd = dans.rdata;
    rb = dans.rbit;
  endtask
  task automatic xa(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    xreq <= {1'b1, w, a, d};
    @(posedge clk);
    xreq.valid <= 1'b0;
    #1 rd = xans.rdata;
    rb = xans.ack;
  endtask
  // op codes: 0 read, 1 program, 2 erase; n counts cycles to the ack
  task automatic fa(input logic [1:0] o, input logic [13:0] a,
                    input logic [7:0] d);
    @(posedge clk);
    creq <= {1'b1, o, a, d};
    @(posedge clk);
    creq.valid <= 1'b0;
    n = 1;
    #1 while (!cans.ack && n < 600) begin
      @(posedge clk);
      #1 n++;
    end
    rd = cans.rdata;
  endtask
  task automatic t_dual();
    da(1'b1, 2'h1, 8'h90, 8'hA5);
    da(1'b1, 2'h0, 8'h90, 8'h3C);
    da(1'b0, 2'h1, 8'h90, 8'h00);
    chk(rd, 8'hA5);
    da(1'b0, 2'h0, 8'h90, 8'h00);
    chk(rd, 8'h3C);
    da(1'b1, 2'h0, 8'h7F, 8'h77);
    da(1'b0, 2'h1, 8'h7F, 8'h00);
    chk(rd, 8'h77);
  endtask
  task automatic t_bank();
    for (int b = 0; b < 4; b++) begin
      @(posedge clk);
      psw_bank <= b[1:0];
      da(1'b1, 2'h2, 8'h03, 8'h10 + 8'(b));
      da(1'b0, 2'h1, {3'h0, b[1:0], 3'h3}, 8'h00);
      chk(rd, 8'h10 + 8'(b));
    end
  endtask
  task automatic t_bit();
    da(1'b1, 2'h1, 8'h2F, 8'h00);
    da(1'b1, 2'h3, 8'h7D, 8'h00, 1'b1);
    da(1'b0, 2'h1, 8'h2F, 8'h00);
    chk(rd, 8'h20);
    da(1'b0, 2'h3, 8'h7D, 8'h00);
    chk(rb, 1'b1);
    da(1'b1, 2'h0, 8'h88, 8'h00);
    da(1'b1, 2'h3, 8'h8B, 8'h00, 1'b1);
    da(1'b0, 2'h0, 8'h88, 8'h00);
    chk(rd, 8'h08);
  endtask
  task automatic t_hold();
    da(1'b1, 2'h1, 8'h40, 8'h11);
    @(posedge clk);
    ce <= 1'b0;
    da(1'b1, 2'h1, 8'h40, 8'h22);
    @(posedge clk);
    ce <= 1'b1;
    da(1'b0, 2'h1, 8'h40, 8'h00);
    chk(rd, 8'h11);
  endtask
  task automatic t_mem();
    fa(2'h2, 14'h0205, 8'h00);
    chk(n, 16'h0201);
    fa(2'h0, 14'h03FF, 8'h00);
    chk(rd, 8'hFF);
    fa(2'h1, 14'h0200, 8'h5A);
    fa(2'h1, 14'h0200, 8'h0F);
    fa(2'h0, 14'h0200, 8'h00);
    chk(rd, 8'h0A);
    xa(1'b1, 16'h0401, 8'h5A);
    chk(rb, 1'b1);
    xa(1'b1, 16'h0001, 8'hC3);
    xa(1'b0, 16'h0401, 8'h00);
    chk(rd, 8'h5A);
    xa(1'b1, 16'h0801, 8'hEE);
    xa(1'b0, 16'h0801, 8'h00);
    chk(rd, 8'h00);
    xa(1'b0, 16'h0001, 8'h00);
    chk(rd, 8'hC3);
  endtask
  task automatic test_done();
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_dual();
    t_bank();
    t_bit();
    t_hold();
    t_mem();
    test_done();
  end
endmodule
bind dmad_decode dmad_chk chk_u (.clk(clk), .rstn(rstn), .ce(ce),
  .dreq(dreq), .dans(dans), .sfr(sfr), .sfr_rdata(sfr_rdata),
  .creq(creq), .cready(cready), .cans(cans));

// *** bench/dmad_sfr_model.sv ***
`timescale 1ns/10ps
module dmad_sfr_model (
  input wire logic clk,
  input wire dmad_pkg::dmad_sfr_t sfr,
  output logic [7:0] sfr_rdata
);
  logic [7:0] mem [128];
  logic [7:0] last = 8'h5A;
  // unselected: inverse of last value, so a stale read cannot pass
  assign sfr_rdata = sfr.rd ? mem[sfr.addr] : ~last;
  always @(posedge clk) begin
    if (sfr.rd) last <= mem[sfr.addr];
    if (sfr.wr) mem[sfr.addr] <= sfr.wdata;
  end
endmodule

// *** common/dmad_map.svh ***
`ifndef DMAD_MAP_SVH
`define DMAD_MAP_SVH
`define DMAD_IRAM_BYTES 256
`define DMAD_UPPER_BIT 7
`define DMAD_BITAREA_BASE 8'h20
`define DMAD_SFR_BASE 8'h80
`define DMAD_XRAM_BYTES 1024
`define DMAD_USBF_BYTES 1024
`define DMAD_XRAM_BASE 16'h0000
`define DMAD_USBF_BASE 16'h0400
`define DMAD_XSPACE_END 16'h0800
`define DMAD_TOTAL_RAM 2304
`define DMAD_FLASH_BYTES 16384
`define DMAD_SECTOR_BYTES 512
`define DMAD_ERASED 8'hFF
`define DMAD_UNMAPPED 8'h00
`endif

// *** common/dmad_pkg.sv ***
package dmad_pkg;
  typedef enum logic [1:0] {
    DMAD_DIRECT,
    DMAD_INDIRECT,
    DMAD_REG,
    DMAD_BIT
  } dmad_mode_t;
  typedef enum logic [1:0] {
    DMAD_FREAD,
    DMAD_FPROG,
    DMAD_FERASE,
    DMAD_FNOP
  } dmad_fop_t;
  typedef struct packed {
    logic valid;
    logic we;
    dmad_mode_t mode;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wbit;
  } dmad_dreq_t;
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic rbit;
  } dmad_dans_t;
  typedef struct packed {
    logic valid;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dmad_xreq_t;
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } dmad_xans_t;
  typedef struct packed {
    logic valid;
    dmad_fop_t op;
    logic [13:0] addr;
    logic [7:0] wdata;
  } dmad_creq_t;
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } dmad_cans_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } dmad_sfr_t;
endpackage

// *** src/dmad_decode.sv ***
`timescale 1ns/10ps
`include "dmad_map.svh"
module dmad_decode (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [1:0] psw_bank,
  input wire dmad_pkg::dmad_dreq_t dreq,
  output dmad_pkg::dmad_dans_t dans,
  output dmad_pkg::dmad_sfr_t sfr,
  input wire logic [7:0] sfr_rdata,
  input wire dmad_pkg::dmad_xreq_t xreq,
  output dmad_pkg::dmad_xans_t xans,
  input wire dmad_pkg::dmad_creq_t creq,
  output logic cready,
  output dmad_pkg::dmad_cans_t cans
);
  localparam int XBYTES = `DMAD_XRAM_BYTES + `DMAD_USBF_BYTES;
  localparam int TOTAL = `DMAD_IRAM_BYTES + XBYTES;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic rbit;
    logic xack;
    logic [7:0] xrdata;
  } dmad_state_t;

  logic [7:0] iram [`DMAD_IRAM_BYTES];
  logic [7:0] xram [XBYTES];
  dmad_state_t s;
  dmad_state_t next_s;
  logic iram_we;
  logic [7:0] iram_wa;
  logic [7:0] iram_wd;
  logic xram_we;
  logic [10:0] xram_wa;
  logic [7:0] xram_wd;
  logic [7:0] bit_byte;
  logic [7:0] bit_mask;
  logic [7:0] cur;

  ////////////////////////////////////////////////////////////////////////////
  // internal data space

  // bit number sits in the low three address bits
  assign bit_mask = 8'h01 << dreq.addr[2:0];

  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    next_s.xack = 1'b0;
    iram_we = 1'b0;
    iram_wa = dreq.addr;
    iram_wd = dreq.wdata;
    sfr = '0;
    bit_byte = 8'h00;
    cur = 8'h00;
    if (dreq.valid) begin
      next_s.ack = 1'b1;
      case (dreq.mode)
        dmad_pkg::DMAD_REG: begin
          iram_wa = {3'b000, psw_bank, dreq.addr[2:0]};
          iram_we = dreq.we;
          next_s.rdata = iram[iram_wa];
        end
        dmad_pkg::DMAD_DIRECT: begin
          if (dreq.addr[`DMAD_UPPER_BIT]) begin
            // upper half by direct address is register space, not RAM
            sfr.rd = !dreq.we;
            sfr.wr = dreq.we;
            sfr.addr = dreq.addr[6:0];
            sfr.wdata = dreq.wdata;
            next_s.rdata = sfr_rdata;
          end else begin
            iram_we = dreq.we;
            next_s.rdata = iram[dreq.addr];
          end
        end
        dmad_pkg::DMAD_INDIRECT: begin
          // the whole space is RAM by pointer, upper half included
          iram_we = dreq.we;
          next_s.rdata = iram[dreq.addr];
        end
        dmad_pkg::DMAD_BIT: begin
          if (dreq.addr[`DMAD_UPPER_BIT]) begin
            // register bits: one-cycle read-modify-write on the sfr port
            bit_byte = {dreq.addr[7:3], 3'b000};
            sfr.rd = 1'b1;
            sfr.wr = dreq.we;
            sfr.addr = bit_byte[6:0];
            cur = sfr_rdata;
            sfr.wdata = dreq.wbit ? (cur | bit_mask) : (cur & ~bit_mask);
          end else begin
            bit_byte = `DMAD_BITAREA_BASE + {4'h0, dreq.addr[6:3]};
            iram_wa = bit_byte;
            cur = iram[bit_byte];
            iram_we = dreq.we;
            iram_wd = dreq.wbit ? (cur | bit_mask) : (cur & ~bit_mask);
          end
          next_s.rdata = cur;
          next_s.rbit = |(cur & bit_mask);
        end
        default: next_s.ack = 1'b1;
      endcase
    end
    // external data space: general RAM then the endpoint fifo RAM
    // kept in the same process: next_s must have a single driver
    xram_we = 1'b0;
    xram_wa = xreq.addr[10:0];
    xram_wd = xreq.wdata;
    if (xreq.valid) begin
      next_s.xack = 1'b1;
      if (xreq.addr < `DMAD_XSPACE_END) begin
        xram_we = xreq.we;
        next_s.xrdata = xram[xram_wa];
      end else begin
        // unmapped: writes dropped so stray pointers corrupt nothing
        next_s.xrdata = `DMAD_UNMAPPED;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && iram_we) begin
      iram[iram_wa] <= iram_wd;
    end
    if (ce && xram_we) begin
      xram[xram_wa] <= xram_wd;
    end
  end

  assign dans.ack = s.ack;
  assign dans.rdata = s.rdata;
  assign dans.rbit = s.rbit;
  assign xans.ack = s.xack;
  assign xans.rdata = s.xrdata;

  ////////////////////////////////////////////////////////////////////////////
  // program memory

  dmad_flash #(
    .FLASH_BYTES(`DMAD_FLASH_BYTES),
    .SECTOR_BYTES(`DMAD_SECTOR_BYTES)
  ) u_flash (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .creq(creq),
    .cready(cready),
    .cans(cans)
  );
endmodule

// *** src/dmad_flash.sv ***
`timescale 1ns/10ps
`include "dmad_map.svh"
module dmad_flash #(
  parameter int FLASH_BYTES = `DMAD_FLASH_BYTES,
  parameter int SECTOR_BYTES = `DMAD_SECTOR_BYTES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire dmad_pkg::dmad_creq_t creq,
  output logic cready,
  output dmad_pkg::dmad_cans_t cans
);
  localparam int AW = $clog2(FLASH_BYTES);
  localparam int SW = $clog2(SECTOR_BYTES);
  typedef enum logic {DMAD_F_IDLE, DMAD_F_ERASE} dmad_fst_t;
  typedef struct packed {
    dmad_fst_t st;
    logic [AW-SW-1:0] sec;
    logic [SW-1:0] cnt;
    logic ack;
    logic [7:0] rdata;
  } dmad_fstate_t;

  logic [7:0] mem [FLASH_BYTES];
  dmad_fstate_t s;
  dmad_fstate_t next_s;
  logic mem_we;
  logic [AW-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [AW-1:0] ra;

  ////////////////////////////////////////////////////////////////////////////
  assign ra = creq.addr[AW-1:0];
  // no requests while a sector erase walks its bytes
  assign cready = (s.st == DMAD_F_IDLE);
  assign cans.ack = s.ack;
  assign cans.rdata = s.rdata;

  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    mem_we = 1'b0;
    mem_wa = ra;
    mem_wd = `DMAD_ERASED;
    case (s.st)
      DMAD_F_IDLE: begin
        if (creq.valid) begin
          next_s.ack = (creq.op != dmad_pkg::DMAD_FERASE);
          if (creq.op == dmad_pkg::DMAD_FREAD) begin
            next_s.rdata = mem[ra];
          end else if (creq.op == dmad_pkg::DMAD_FPROG) begin
            // programming only clears bits; erase is the way back to ones
            mem_we = 1'b1;
            mem_wd = mem[ra] & creq.wdata;
          end else if (creq.op == dmad_pkg::DMAD_FERASE) begin
            next_s.st = DMAD_F_ERASE;
            next_s.sec = ra[AW-1:SW];
            next_s.cnt = '0;
          end
        end
      end
      DMAD_F_ERASE: begin
        mem_we = 1'b1;
        mem_wa = {s.sec, s.cnt};
        next_s.cnt = s.cnt + 1'b1;
        if (&s.cnt) begin
          next_s.st = DMAD_F_IDLE;
          next_s.ack = 1'b1;
        end
      end
      default: next_s.st = DMAD_F_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // array kept out of reset: flash contents survive it
  always_ff @(posedge clk) begin
    if (ce && mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end
endmodule
